/* common/tmc_pkg.sv */
// Package of constants and types for the triple timer/counter core
package tmc_pkg;

   // Register bus widths
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   // Register offsets
   localparam logic [3:0] ADDR_T0_CTRL = 4'h0;  // Timer zero control
   localparam logic [3:0] ADDR_T0_LOW = 4'h1;   // Timer zero count, low byte
   localparam logic [3:0] ADDR_T0_HIGH = 4'h2;  // Timer zero count, high byte
   localparam logic [3:0] ADDR_T1_COUNT = 4'h3; // Second timer count
   localparam logic [3:0] ADDR_T2_COUNT = 4'h4; // Third timer count
   localparam logic [3:0] ADDR_PERIOD1 = 4'h5;  // Second timer period
   localparam logic [3:0] ADDR_PERIOD2 = 4'h6;  // Third timer period
   localparam logic [3:0] ADDR_T12_CTRL = 4'h7; // Second/third timer control
   localparam logic [3:0] ADDR_FLAGS = 4'h8;    // Rollover flags, W1C

   // Field positions in the timer zero control register
   localparam int T0_EDGE_BIT = 6;  // 1 = falling edge of the pin counts
   localparam int T0_SRC_BIT = 5;   // 1 = external pin, 0 = instr clock
   localparam int T0_PS_MSB = 4;    // Prescale select, top bit
   localparam int T0_PS_LSB = 1;    // Prescale select, bottom bit
   localparam logic [7:0] T0_CTRL_MASK = 8'h7E; // Bits 7 and 0 read zero

   // Field positions in the flag register
   localparam int FLAG_ONE_BIT = 0;
   localparam int FLAG_TWO_BIT = 1;

   // Reset values
   localparam logic [7:0] T0_CTRL_RST = 8'h00;
   localparam logic [7:0] T12_CTRL_RST = 8'h00;
   localparam logic [7:0] PERIOD_RST = 8'hFF;
   localparam logic [7:0] COUNT8_RST = 8'h00;
   localparam logic [15:0] COUNT16_RST = 16'h0000;

   // Timing: instruction clock is the device clock divided by four
   localparam int INSTR_DIV = 4;
   localparam int PS_CODE_W = 4;    // Width of the prescale select code
   localparam int PS_MAX_SHIFT = 8; // Largest ratio is 2**8 = 256

   // Second/third timer control layout (bit 7 down to bit 0)
   typedef struct packed {
      logic reserved;  // Reads zero
      logic twoIrqEn;  // Third timer interrupt enable
      logic oneIrqEn;  // Second timer interrupt enable
      logic chain;     // 1 = one 16-bit timer
      logic twoExt;    // Third timer counts the shared pin
      logic oneExt;    // Second timer counts the shared pin
      logic twoRun;    // Third timer running
      logic oneRun;    // Second timer running
   } tmc_t12_ctrl_t;

   // Time base handed to the pulse-width outputs
   typedef struct packed {
      logic [7:0] countOne;  // Second timer count
      logic [7:0] countTwo;  // Third timer count
      logic rollOne;         // Second timer (or chain) rolled over
      logic rollTwo;         // Third timer rolled over
   } tmc_timebase_t;

endpackage

/* verilog/tmc_prescaler.sv */
// Power-of-two event prescaler for the first timer
`timescale 1ns/1ps
module tmc_prescaler #(
   parameter int CNT_W = 8  // Counter width, 2**CNT_W is the top ratio
) (
   input wire logic mclk,                          // Device clock
   input wire logic rstn,                          // Async reset, low
   input wire logic ce,                            // Clock enable
   input wire logic clear,                         // Restart the division
   input wire logic event_in,                      // Qualified event pulse
   input wire logic [tmc_pkg::PS_CODE_W-1:0] sel,  // Prescale select
   output logic tick                               // Prescaled pulse
);

   logic [CNT_W-1:0] count;    // Events seen in this period
   logic [CNT_W-1:0] divMask;  // Bits that must all be one to emit
   logic [3:0] shift;          // Decoded ratio exponent

   // Codes with the top bit set all mean the largest ratio
   always_comb
   begin
      if (sel[tmc_pkg::PS_CODE_W-1])
         shift = 4'(tmc_pkg::PS_MAX_SHIFT);
      else
         shift = {1'b0, sel[tmc_pkg::PS_CODE_W-2:0]};
   end

   // One mask bit per counter bit: ratio is two to the decoded exponent
   genvar i;
   generate
      for (i = 0; i < CNT_W; i++)
      begin : g_mask
         assign divMask[i] = (32'(shift) > i);
      end
   endgenerate

   // Count events; emit one tick per full ratio
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         count <= '0;
         tick <= 1'b0;
      end
      else if (ce)
      begin
         tick <= 1'b0;
         if (clear)
            count <= '0;
         else if (event_in)
         begin
            if ((count & divMask) == divMask)
            begin
               count <= '0;
               tick <= 1'b1;
            end
            else
               count <= count + 1'b1;
         end
      end
   end

endmodule

/* verilog/tmc_timer_core.sv */
// Three timer/counters with a plain register port
//
// Function
// - First timer: 16-bit wrapping up counter
// - First timer clock: instruction clock or pin
// - Software picks rising or falling pin edge
// - Prescale select in control bits 4:1
// - Prescale ratios 1 to 256, powers of two
// - External clock synchronised before the prescaler
// - Second timer 8-bit, period match sets flag
// - Third timer 8-bit, period match sets flag
// - Shared pin may clock second and third
// - Second and third chain into 16-bit timer
// - Chained rollover sets the second timer flag
// - Second/third timers feed pulse-width time base
`timescale 1ns/1ps
module tmc_timer_core (
   input wire logic mclk,                        // Device clock, 10 MHz
   input wire logic rstn,                        // Async reset, active low
   input wire logic ce,                          // Clock enable, freezes all
   input wire logic [tmc_pkg::ADDR_W-1:0] addr,  // Register address
   input wire logic [tmc_pkg::DATA_W-1:0] wdata, // Write data
   input wire logic wr,                          // Write strobe
   input wire logic rd,                          // Read strobe
   input wire logic timerZeroExtClockPin,        // First timer pin, async
   input wire logic sharedCounterClockPin,       // Shared pin, async
   output logic [tmc_pkg::DATA_W-1:0] rdata,     // Read data, next cycle
   output logic [15:0] timerZeroCount,           // First timer count
   output tmc_pkg::tmc_timebase_t timeBase,      // Pulse-width time base
   output logic timerOneIrq,                     // Second timer interrupt
   output logic timerTwoIrq                      // Third timer interrupt
);

   // Software state
   logic [7:0] timerZeroControl;    // Edge, source, prescale
   tmc_pkg::tmc_t12_ctrl_t t12Ctrl; // Second/third timer control
   logic [7:0] periodOne;           // Second timer period
   logic [7:0] periodTwo;           // Third timer period
   logic [7:0] timerOneCount;       // Second timer count
   logic [7:0] timerTwoCount;       // Third timer count
   logic timerOneFlag;              // Second timer rollover flag
   logic timerTwoFlag;              // Third timer rollover flag

   // Clock and pin conditioning
   logic [1:0] instrDiv;            // Device clock divider
   logic instrTick;                 // One pulse per instruction cycle
   logic [2:0] zeroPinSync;         // Sync pair plus history
   logic [2:0] sharedPinSync;       // Sync pair plus history
   logic zeroEdge;                  // Selected edge of first timer pin
   logic sharedEdge;                // Rising edge of shared pin
   logic zeroEvent;                 // Event into the prescaler
   logic zeroTick;                  // Prescaled increment
   logic zeroLoad;                  // Software writes first timer count

   // Second/third timer stepping
   logic oneTick;                   // Second timer qualified event
   logic twoTick;                   // Third timer qualified event
   logic oneMatch;                  // Second timer at its period
   logic twoMatch;                  // Third timer at its period
   logic chainMatch;                // Chained count at 16-bit period
   logic oneRoll;                   // Second timer (or chain) rollover
   logic twoRoll;                   // Third timer rollover
   logic [7:0] flagClear;           // Write-one-to-clear pattern

   // Bus decode helpers
   logic wrT0Low;
   logic wrT0High;
   logic wrOneCount;
   logic wrTwoCount;

   assign wrT0Low = wr && (addr == tmc_pkg::ADDR_T0_LOW);
   assign wrT0High = wr && (addr == tmc_pkg::ADDR_T0_HIGH);
   assign wrOneCount = wr && (addr == tmc_pkg::ADDR_T1_COUNT);
   assign wrTwoCount = wr && (addr == tmc_pkg::ADDR_T2_COUNT);
   assign zeroLoad = wrT0Low || wrT0High;
   assign flagClear = (wr && (addr == tmc_pkg::ADDR_FLAGS)) ? wdata : 8'h00;

   // Instruction clock: device clock divided by four
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         instrDiv <= 2'h0;
      else if (ce)
         instrDiv <= instrDiv + 2'h1;
   end

   assign instrTick = (instrDiv == 2'(tmc_pkg::INSTR_DIV - 1));

   // Pin synchronisers; only stage 1 and history reach any logic
   // Limitation: one clock domain, so pin pulses must be slower than
   // half the device clock; the prescaler then divides the events.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         zeroPinSync <= 3'h0;
         sharedPinSync <= 3'h0;
      end
      else if (ce)
      begin
         zeroPinSync <= {zeroPinSync[1:0], timerZeroExtClockPin};
         sharedPinSync <= {sharedPinSync[1:0], sharedCounterClockPin};
      end
   end

   // Edge choice for the first timer pin
   always_comb
   begin
      if (timerZeroControl[tmc_pkg::T0_EDGE_BIT])
         zeroEdge = zeroPinSync[2] && !zeroPinSync[1];
      else
         zeroEdge = !zeroPinSync[2] && zeroPinSync[1];
   end

   assign sharedEdge = !sharedPinSync[2] && sharedPinSync[1];

   // Source select for the first timer
   assign zeroEvent = timerZeroControl[tmc_pkg::T0_SRC_BIT] ? zeroEdge
                                                             : instrTick;

   // Prescaler; a count write restarts the division
   tmc_prescaler #(
      .CNT_W(tmc_pkg::PS_MAX_SHIFT)
   ) u_prescaler (
      .mclk(mclk),
      .rstn(rstn),
      .ce(ce),
      .clear(zeroLoad),
      .event_in(zeroEvent),
      .sel(timerZeroControl[tmc_pkg::T0_PS_MSB:tmc_pkg::T0_PS_LSB]),
      .tick(zeroTick)
   );

   // Control registers written by software
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         timerZeroControl <= tmc_pkg::T0_CTRL_RST;
         t12Ctrl <= tmc_pkg::T12_CTRL_RST;
         periodOne <= tmc_pkg::PERIOD_RST;
         periodTwo <= tmc_pkg::PERIOD_RST;
      end
      else if (ce && wr)
      begin
         case (addr)
            tmc_pkg::ADDR_T0_CTRL:
               timerZeroControl <= wdata & tmc_pkg::T0_CTRL_MASK;
            tmc_pkg::ADDR_T12_CTRL:
               t12Ctrl <= {1'b0, wdata[6:0]};
            tmc_pkg::ADDR_PERIOD1:
               periodOne <= wdata;
            tmc_pkg::ADDR_PERIOD2:
               periodTwo <= wdata;
            default:
               ;  // Counts and flags are handled below
         endcase
      end
   end

   // First timer: 16-bit counter that simply wraps
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         timerZeroCount <= tmc_pkg::COUNT16_RST;
      else if (ce)
      begin
         if (wrT0Low)
            timerZeroCount[7:0] <= wdata;  // Write beats increment
         else if (wrT0High)
            timerZeroCount[15:8] <= wdata;
         else if (zeroTick)
            timerZeroCount <= timerZeroCount + 16'h0001;
      end
   end

   // Clock choice for second and third timers: shared pin or instr
   assign oneTick = t12Ctrl.oneRun && (t12Ctrl.oneExt ? sharedEdge
                                                      : instrTick);
   assign twoTick = t12Ctrl.twoRun && (t12Ctrl.twoExt ? sharedEdge
                                                      : instrTick);

   assign oneMatch = (timerOneCount == periodOne);
   assign twoMatch = (timerTwoCount == periodTwo);
   // Low byte is the second timer, high byte the third
   assign chainMatch = ({timerTwoCount, timerOneCount}
                        == {periodTwo, periodOne});

   // In chained mode the second timer's clock drives the pair
   assign oneRoll = oneTick && (t12Ctrl.chain ? chainMatch : oneMatch);
   assign twoRoll = !t12Ctrl.chain && twoTick && twoMatch;

   // Second timer count; stops when not running
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         timerOneCount <= tmc_pkg::COUNT8_RST;
      else if (ce)
      begin
         if (wrOneCount)
            timerOneCount <= wdata;
         else if (oneRoll)
            timerOneCount <= 8'h00;
         else if (oneTick)
            timerOneCount <= timerOneCount + 8'h01;
      end
   end

   // Third timer count; carries from the second when chained
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         timerTwoCount <= tmc_pkg::COUNT8_RST;
      else if (ce)
      begin
         if (wrTwoCount)
            timerTwoCount <= wdata;
         else if (t12Ctrl.chain)
         begin
            if (oneRoll)
               timerTwoCount <= 8'h00;
            else if (oneTick && (timerOneCount == 8'hFF))
               timerTwoCount <= timerTwoCount + 8'h01;
         end
         else if (twoRoll)
            timerTwoCount <= 8'h00;
         else if (twoTick)
            timerTwoCount <= timerTwoCount + 8'h01;
      end
   end

   // Rollover flags; a new rollover wins over a clear in the same cycle
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         timerOneFlag <= 1'b0;
         timerTwoFlag <= 1'b0;
      end
      else if (ce)
      begin
         timerOneFlag <= (timerOneFlag && !flagClear[tmc_pkg::FLAG_ONE_BIT])
                         || oneRoll;
         timerTwoFlag <= (timerTwoFlag && !flagClear[tmc_pkg::FLAG_TWO_BIT])
                         || twoRoll;
      end
   end

   // Interrupt requests are flag and enable, registered for clean pins
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         timerOneIrq <= 1'b0;
         timerTwoIrq <= 1'b0;
      end
      else if (ce)
      begin
         timerOneIrq <= timerOneFlag && t12Ctrl.oneIrqEn;
         timerTwoIrq <= timerTwoFlag && t12Ctrl.twoIrqEn;
      end
   end

   // Time base for the pulse-width outputs, one cycle behind the counts
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         timeBase <= '0;
      else if (ce)
      begin
         timeBase.countOne <= timerOneCount;
         timeBase.countTwo <= timerTwoCount;
         timeBase.rollOne <= oneRoll;
         timeBase.rollTwo <= twoRoll;
      end
   end

   // Read port: data stands only in the cycle after the strobe
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         rdata <= 8'h00;
      else if (ce)
      begin
         if (!rd)
            rdata <= 8'h00;
         else
         begin
            case (addr)
               tmc_pkg::ADDR_T0_CTRL:
                  rdata <= timerZeroControl;
               tmc_pkg::ADDR_T0_LOW:
                  rdata <= timerZeroCount[7:0];
               tmc_pkg::ADDR_T0_HIGH:
                  rdata <= timerZeroCount[15:8];
               tmc_pkg::ADDR_T1_COUNT:
                  rdata <= timerOneCount;
               tmc_pkg::ADDR_T2_COUNT:
                  rdata <= timerTwoCount;
               tmc_pkg::ADDR_PERIOD1:
                  rdata <= periodOne;
               tmc_pkg::ADDR_PERIOD2:
                  rdata <= periodTwo;
               tmc_pkg::ADDR_T12_CTRL:
                  rdata <= t12Ctrl;
               tmc_pkg::ADDR_FLAGS:
                  rdata <= {6'h00, timerTwoFlag, timerOneFlag};
               default:
                  rdata <= 8'h00;  // Unmapped reads as zero
            endcase
         end
      end
   end

endmodule

/* dv/tmc_timer_core_properties.sv */
// Port-level checker for the triple timer core
`timescale 1ns/1ps
module tmc_timer_core_properties (
   input wire logic mclk, // Clock
   input wire logic rstn, // Reset, low
   input wire logic ce, // Clock enable
   input wire logic [3:0] addr, // Address
   input wire logic [7:0] wdata, // Write data
   input wire logic wr, // Write strobe
   input wire logic rd, // Read strobe
   input wire logic [7:0] rdata, // Read data
   input wire logic [15:0] timerZeroCount, // First count
   input wire tmc_pkg::tmc_timebase_t timeBase // Time base
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);
   // Read data stands one cycle, zero otherwise
   a_read_idle_zero: assert property (
      ce && !rd |=> rdata == 8'h00) else $error("rdata not zero when idle");
   // Holes in the map read as zero
   a_unmapped_zero: assert property (
      ce && rd && addr > 4'h8 |=> rdata == 8'h00) else $error("hole not zero");
   // Bit 0 of the control register is unimplemented
   a_ctrl_spare: assert property (
      ce && rd && addr == tmc_pkg::ADDR_T0_CTRL |=> rdata[0] == 1'b0)
      else $error("control bit 0 not zero");
   // A count write wins over an increment
   a_low_write: assert property (
      ce && wr && addr == tmc_pkg::ADDR_T0_LOW |=>
      timerZeroCount[7:0] == $past(wdata)) else $error("low byte lost");
   a_high_write: assert property (
      ce && wr && addr == tmc_pkg::ADDR_T0_HIGH |=>
      timerZeroCount[15:8] == $past(wdata)) else $error("high byte lost");
   // The count never jumps; 16-bit difference also covers the wrap
   a_step_by_one: assert property (
      ce && !wr |=> 16'(timerZeroCount - $past(timerZeroCount)) <= 16'h0001)
      else $error("count jumped");
   // Enable low freezes every count
   a_freeze: assert property (
      !ce |=> $stable(timerZeroCount) && $stable(timeBase))
      else $error("count moved while frozen");
   // A rollover pulse comes with a zero count
   a_one_roll_zero: assert property (
      timeBase.rollOne |-> ##[0:2] timeBase.countOne == 8'h00)
      else $error("second timer roll without zero");
   a_two_roll_zero: assert property (
      timeBase.rollTwo |-> ##[0:2] timeBase.countTwo == 8'h00)
      else $error("third timer roll without zero");
   // Second timer rollover marks are single pulses
   a_roll_pulse: assert property (
      timeBase.rollOne && ce |=> !timeBase.rollOne)
      else $error("roll pulse too long");
endmodule
bind tmc_timer_core tmc_timer_core_properties chk_u (.mclk, .rstn, .ce,
   .addr, .wdata, .wr, .rd, .rdata, .timerZeroCount, .timeBase);

/* dv/tmc_clock_source.sv */
// Model of the two external clock sources
`timescale 1ns/1ps
module tmc_clock_source (
   input wire logic mclk, // Device clock
   output logic zeroPin, // First timer pin
   output logic sharedPin // Shared pin
);
   // Pins idle low and stand still between bursts
   initial
   begin
      zeroPin = 1'b0;
      sharedPin = 1'b0;
   end
   // Set one pin, then hold it; phases must outlast the synchroniser
   task automatic drive(input logic which, input logic lvl, input int hold);
      @(posedge mclk);
      if (which)
         sharedPin <= lvl;
      else
         zeroPin <= lvl;
      repeat (hold) @(posedge mclk);
   endtask
   // Whole pulses, quick or slow by the hold figure
   task automatic pulse(input logic which, input int n, input int hold);
      repeat (n)
      begin
         drive(which, 1'b1, hold);
         drive(which, 1'b0, hold);
      end
   endtask
endmodule

/* dv/tb.sv */
// Self-checking bench for the triple timer core
`timescale 1ns/1ps
module tb;
   logic mclk, rstn, ce, wr, rd, zeroPin, sharedPin;
   logic timerOneIrq, timerTwoIrq;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, rv, rnd;
   logic [15:0] timerZeroCount, c0;
   tmc_pkg::tmc_timebase_t timeBase;
   int badCount, testsRun, n, k;
   int ra[8] = '{0, 3, 4, 5, 6, 7, 8, 15}; // Reset table addresses
   int rv0[8] = '{0, 0, 0, 255, 255, 0, 0, 0}; // Reset table values
   tmc_timer_core dut_u (.mclk, .rstn, .ce, .addr, .wdata, .wr, .rd,
      .timerZeroExtClockPin(zeroPin), .sharedCounterClockPin(sharedPin),
      .rdata, .timerZeroCount, .timeBase, .timerOneIrq, .timerTwoIrq);
   tmc_clock_source src_u (.mclk, .zeroPin, .sharedPin);
   // 10 MHz clock
   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic logic roll(input logic two);
      return two ? timeBase.rollTwo : timeBase.rollOne;
   endfunction
   task automatic chk(input string what, input logic [15:0] exp,
      input logic [15:0] got);
      testsRun++;
      if (got !== exp)
      begin
         badCount++;
         $display("wrong value %s exp %h got %h", what, exp, got);
      end
   endtask
   // Rate checks allow one count of phase slack
   task automatic near(input string what, input int exp,
      input logic [15:0] got);
      testsRun++;
      if (!(got === 16'(exp) || got === 16'(exp + 1) || got === 16'(exp - 1)))
      begin
         badCount++;
         $display("wrong value %s exp %0d got %h", what, exp, got);
      end
   endtask
   task automatic wrReg(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   // Read data is taken in the cycle after the strobe
   task automatic rdReg(input logic [3:0] a, output logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      @(negedge mclk);
      d = rdata;
   endtask
   // Cycles between two rollover pulses, bounded
   task automatic gap(input logic two, output int n);
      int j;
      n = 0;
      j = 0;
      @(negedge mclk);
      while (roll(two) !== 1'b1 && j < 3000)
      begin
         @(negedge mclk);
         j++;
      end
      do
      begin
         @(negedge mclk);
         n++;
      end
      while (roll(two) !== 1'b1 && n < 3000);
   endtask
   task automatic edgeCase(input logic [7:0] ctl, input int up, input int dn);
      wrReg(tmc_pkg::ADDR_T0_CTRL, ctl);
      @(negedge mclk);
      c0 = timerZeroCount;
      src_u.drive(1'b0, 1'b1, 3);
      repeat (4) @(negedge mclk);
      chk("edge up", 16'(up), timerZeroCount - c0);
      src_u.drive(1'b0, 1'b0, 3);
      repeat (4) @(negedge mclk);
      chk("edge down", 16'(dn), timerZeroCount - c0);
   endtask
   task automatic printVerdict();
      $display("checks %0d mismatches %0d", testsRun, badCount);
      if (badCount == 0 && testsRun > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Watchdog, well past the expected 25k cycles
   initial
   begin
      #(100 * 60000);
      badCount++;
      printVerdict();
   end
   initial
   begin
      rstn = 1'b0;
      ce = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 8'h00;
      badCount = 0;
      testsRun = 0;
      rnd = 8'h60;
      repeat (6) @(posedge mclk);
      rstn <= 1'b1;
      for (k = 0; k < 8; k++)
      begin
         rdReg(4'(ra[k]), rv);
         chk("reset value", 16'(rv0[k]), rv);
      end
      wrReg(tmc_pkg::ADDR_T0_CTRL, 8'hFF);
      rdReg(tmc_pkg::ADDR_T0_CTRL, rv);
      chk("ctrl mask", 16'h007E, rv);
      // Every ratio, plus a code with the top bit set
      for (k = 0; k < 10; k++)
      begin
         n = (k == 9) ? 15 : k;
         wrReg(tmc_pkg::ADDR_T0_CTRL, 8'(n << 1));
         wrReg(tmc_pkg::ADDR_T0_LOW, 8'h00);
         @(negedge mclk);
         c0 = timerZeroCount;
         repeat (2048) @(negedge mclk);
         near("prescale", 512 >> (n > 8 ? 8 : n), timerZeroCount - c0);
      end
      edgeCase(8'h20, 1, 1);
      edgeCase(8'h60, 0, 1);
      // Slow pin through a divide by four
      wrReg(tmc_pkg::ADDR_T0_CTRL, 8'h24);
      wrReg(tmc_pkg::ADDR_T0_LOW, 8'h00);
      @(negedge mclk);
      c0 = timerZeroCount;
      src_u.pulse(1'b0, 8, 6);
      repeat (6) @(negedge mclk);
      chk("pin prescale", 16'h0002, timerZeroCount - c0);
      wrReg(tmc_pkg::ADDR_T0_CTRL, 8'h00);
      @(posedge mclk);
      ce <= 1'b0;
      @(negedge mclk);
      c0 = timerZeroCount;
      repeat (20) @(negedge mclk);
      chk("frozen", c0, timerZeroCount);
      @(posedge mclk);
      ce <= 1'b1;
      // Both bytes of the first count, then a wrap through zero
      wrReg(tmc_pkg::ADDR_T0_LOW, 8'hF0);
      wrReg(tmc_pkg::ADDR_T0_HIGH, 8'hFF);
      rdReg(tmc_pkg::ADDR_T0_HIGH, rv);
      chk("high byte", 16'h00FF, rv);
      @(negedge mclk);
      c0 = timerZeroCount;
      repeat (100) @(negedge mclk);
      near("wrap", 25, timerZeroCount - c0);
      rdReg(tmc_pkg::ADDR_T0_HIGH, rv);
      chk("wrap high", 16'h0000, rv);
      rnd = lfsr(rnd);
      wrReg(tmc_pkg::ADDR_PERIOD1, 8'h09);
      wrReg(tmc_pkg::ADDR_PERIOD2, rnd);
      wrReg(tmc_pkg::ADDR_T12_CTRL, 8'h63);
      gap(1'b0, n);
      chk("period one", 16'h0028, 16'(n));
      gap(1'b1, n);
      chk("period two", 16'(4 * (rnd + 1)), 16'(n));
      rdReg(tmc_pkg::ADDR_FLAGS, rv);
      chk("flags", 16'h0003, rv);
      chk("irq one", 16'h0001, timerOneIrq);
      chk("irq two", 16'h0001, timerTwoIrq);
      gap(1'b0, n);
      wrReg(tmc_pkg::ADDR_FLAGS, 8'h01);
      rdReg(tmc_pkg::ADDR_FLAGS, rv);
      chk("flag clear", 16'h0000, rv & 8'h01);
      repeat (2) @(negedge mclk);
      chk("irq cleared", 16'h0000, timerOneIrq);
      wrReg(tmc_pkg::ADDR_T12_CTRL, 8'h03);
      repeat (2) @(negedge mclk);
      chk("irq masked", 16'h0000, timerTwoIrq);
      // Shared pin clocks both timers
      wrReg(tmc_pkg::ADDR_PERIOD2, 8'hFF);
      wrReg(tmc_pkg::ADDR_T12_CTRL, 8'h0F);
      wrReg(tmc_pkg::ADDR_T1_COUNT, 8'h00);
      wrReg(tmc_pkg::ADDR_T2_COUNT, 8'h00);
      src_u.pulse(1'b1, 5, 3);
      repeat (6) @(negedge mclk);
      rdReg(tmc_pkg::ADDR_T1_COUNT, rv);
      chk("pin count one", 16'h0005, rv);
      rdReg(tmc_pkg::ADDR_T2_COUNT, rv);
      chk("pin count two", 16'h0005, rv);
      // Chained pair, period 0x0102 gives 259 ticks
      wrReg(tmc_pkg::ADDR_T12_CTRL, 8'h00);
      wrReg(tmc_pkg::ADDR_FLAGS, 8'h03);
      wrReg(tmc_pkg::ADDR_T1_COUNT, 8'h00);
      wrReg(tmc_pkg::ADDR_T2_COUNT, 8'h00);
      wrReg(tmc_pkg::ADDR_PERIOD1, 8'h02);
      wrReg(tmc_pkg::ADDR_PERIOD2, 8'h01);
      wrReg(tmc_pkg::ADDR_T12_CTRL, 8'h31);
      gap(1'b0, n);
      chk("chain period", 16'd1036, 16'(n));
      chk("chain irq", 16'h0001, timerOneIrq);
      printVerdict();
   end
endmodule
